// *** rtl/sys_param_consts.vh ***
// Constants for the system parameter page: parameter numbers, byte layouts, timing.
// Assumes a single 25 MHz system clock and a synchronous active-high reset.
// Behaviour
// - Banks 0-1 non-wakeup, banks 2-3 wakeup sensors.
// - Parameter 1 non-wakeup meta, 29 wakeup meta.
// - Parameters 3-6 status banks, read only; 30 timestamps.
// - Eight bytes, two bits per event, enable upper.
// - Enabled meta event queued; interrupt if enabled.
// - Watermark byte count raises interrupt; zero disables.
// - Watermark above capacity treated as capacity.
// - Zero-latency sample interrupts while host active.
// - Watermark governs only in batched or suspended case.
// - FIFO control byte layout, low byte first.
// - Watermarks read/write, sizes read only.
// - Sixteen bytes per bank, type 16b+i+1; the page returns only bytes 0-7 of each bank.
// - Status bits zero to four are error flags.
// - Status bits five to seven hold power mode.
// - Timestamp bytes 0-3 capture at host interrupt.
// - Timestamp bytes 4-7 current time, read only.
// - Captured timestamp readable from direct register window.
// - Parameters exchanged through a handshaked mailbox.
`ifndef SYS_PARAM_CONSTS_VH
`define SYS_PARAM_CONSTS_VH
`define PAR_META_NWK 7'h01
`define PAR_FIFO_CTL 7'h02
`define PAR_BANK0 7'h03
`define PAR_BANK3 7'h06
`define PAR_META_WK 7'h1d
`define PAR_TSTAMP 7'h1e
`define PAR_BYTES 4'h8
`define BANK_BYTES 5'h10
`define REG_WIN_TS0 8'h6c
`define REG_WIN_TS3 8'h6f
`define REG_PAR_NUM 8'h00
`define REG_PAR_DIR 8'h01
`define REG_PAR_REQ 8'h02
`define REG_PAR_ACK 8'h03
`define REG_PAR_IDX 8'h04
`define REG_PAR_DATA 8'h05
`define TICK_HZ 32000
`define CLK_HZ 25000000
`endif

// *** rtl/ts_tick.v ***
// Timebase divider producing one tick per 1/32000 s and the running system time.
// Assumes it runs on the system clock; the fractional rate is kept exact by accumulation.
`timescale 1ns/1ps
`default_nettype none
`include "sys_param_consts.vh"
module ts_tick
(
    // Clock and reset.
    input wire mclk,
    input wire rst,
    // System time.
    output reg [31:0] sysTime_r
);
    reg [31:0] acc_r;
    wire [32:0] accSum = {1'b0, acc_r} + `TICK_HZ;
    // A rate accumulator avoids the drift a rounded integer divider would add.
    always @(posedge mclk)
    begin
        if (rst)
        begin
            acc_r <= 32'h0;
            sysTime_r <= 32'h0;
        end
        else if (accSum >= `CLK_HZ)
        begin
            acc_r <= accSum[31:0] - `CLK_HZ;
            sysTime_r <= sysTime_r + 32'h1;
        end
        else
        begin
            acc_r <= accSum[31:0];
        end
    end
endmodule // ts_tick
`default_nettype wire

// *** rtl/system_parameter_page.v ***
// System parameter page: meta-event control, FIFO watermarks, status banks, timestamps, host interrupt.
// Assumes registers on a plain strobe port, read data one cycle after the read strobe.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "sys_param_consts.vh"
module system_parameter_page
#(
    parameter WK_FIFO_SIZE = 16'h0800,
    parameter NWK_FIFO_SIZE = 16'h0800
)
(
    // Clock and reset.
    input wire mclk,
    input wire rst,
    // Register port.
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata_r,
    // Sensor status bytes, 64 sensors, sensor type t at bits 8*(t-1).
    input wire [511:0] sensorStatus,
    // Meta events: pulse per event, bit k is event k+1.
    input wire [31:0] metaEvtNwk,
    input wire [31:0] metaEvtWk,
    // FIFO fill levels in bytes.
    input wire [15:0] wkFifoLevel,
    input wire [15:0] nwkFifoLevel,
    // Sample and suspend context.
    input wire sampleZeroLat,
    input wire wakeupEvent,
    input wire host_suspended_flag,
    // Meta-event push towards the output FIFOs.
    output reg [31:0] metaPushNwk_r,
    output reg [31:0] metaPushWk_r,
    // Host interrupt.
    output reg hostIrq_r
);
    reg [6:0] parNum_r;
    reg parDir_r;
    reg parAck_r;
    reg [2:0] parIdx_r;
    reg [63:0] wrBuf_r;
    reg [63:0] rdBuf_r;
    reg [63:0] metaNwk_r;
    reg [63:0] metaWk_r;
    reg [15:0] wmWk_r;
    reg [15:0] wmNwk_r;
    reg [31:0] irqTime_r;
    reg [7:0] rdNxt;
    reg [63:0] pageVal;
    reg [31:0] enNwk, ieNwk, enWk, ieWk;
    reg irqMeta;
    wire [31:0] sysTime;
    integer k;

    ts_tick tick
    (
        .mclk(mclk),
        .rst(rst),
        .sysTime_r(sysTime)
    );

    // Clamps the watermark to capacity before comparing against the level.
    function wmHit;
        input [15:0] wm;
        input [15:0] cap;
        input [15:0] lvl;
        begin
            if (wm == 16'h0)
                wmHit = 1'b0;
            else if (wm > cap)
                wmHit = (lvl >= cap);
            else
                wmHit = (lvl >= wm);
        end
    endfunction

    // Selects one 8-byte status slice; banks 0-1 carry non-wakeup sensors, 2-3 wakeup.
    function [63:0] bankHalf;
        input [511:0] st;
        input [1:0] bank;
        input half;
        begin
            bankHalf = st[{bank, half, 6'h0} +: 64];
        end
    endfunction

    always @*
    begin
        for (k = 0; k < 32; k = k + 1)
        begin
            enNwk[k] = metaNwk_r[2 * k + 1];
            ieNwk[k] = metaNwk_r[2 * k];
            enWk[k] = metaWk_r[2 * k + 1];
            ieWk[k] = metaWk_r[2 * k];
        end
        irqMeta = |((metaEvtNwk & enNwk & ieNwk) | (metaEvtWk & enWk & ieWk));
    end

    // Page contents for a parameter read; byte 0 in bits 7:0.
    always @*
    begin
        pageVal = 64'h0;
        if (parNum_r == `PAR_META_NWK)
            pageVal = metaNwk_r;
        else if (parNum_r == `PAR_META_WK)
            pageVal = metaWk_r;
        else if (parNum_r == `PAR_FIFO_CTL)
            pageVal = {NWK_FIFO_SIZE[15:0], wmNwk_r, WK_FIFO_SIZE[15:0], wmWk_r};
        else if (parNum_r == `PAR_TSTAMP)
            pageVal = {sysTime, irqTime_r};
        else if (parNum_r >= `PAR_BANK0 && parNum_r <= `PAR_BANK3)
            pageVal = bankHalf(sensorStatus, parNum_r[1:0] - 2'h3, 1'b0);
    end

    wire irqCause = irqMeta
        | (sampleZeroLat & ~host_suspended_flag)
        | (wakeupEvent)
        | ((host_suspended_flag | ~sampleZeroLat) & ~wakeupEvent
           & (wmHit(wmWk_r, WK_FIFO_SIZE[15:0], wkFifoLevel) | wmHit(wmNwk_r, NWK_FIFO_SIZE[15:0], nwkFifoLevel)));

    always @(posedge mclk)
    begin
        if (rst)
        begin
            hostIrq_r <= 1'b0;
            irqTime_r <= 32'h0;
            metaPushNwk_r <= 32'h0;
            metaPushWk_r <= 32'h0;
        end
        else
        begin
            hostIrq_r <= irqCause;
            if (irqCause && !hostIrq_r)
                irqTime_r <= sysTime;
            metaPushNwk_r <= metaEvtNwk & enNwk;
            metaPushWk_r <= metaEvtWk & enWk;
        end
    end

    // Mailbox: host sets number, direction and buffer, then writes request; ack reports completion.
    always @(posedge mclk)
    begin
        if (rst)
        begin
            parNum_r <= 7'h0;
            parDir_r <= 1'b0;
            parAck_r <= 1'b0;
            parIdx_r <= 3'h0;
            wrBuf_r <= 64'h0;
            rdBuf_r <= 64'h0;
            metaNwk_r <= 64'h0;
            metaWk_r <= 64'h0;
            wmWk_r <= 16'h0;
            wmNwk_r <= 16'h0;
        end
        else if (regWr)
        begin
            case (regAddr)
                `REG_PAR_NUM:
                begin
                    parNum_r <= regWdata[6:0];
                    parAck_r <= 1'b0;
                end
                `REG_PAR_DIR:
                    parDir_r <= regWdata[0];
                `REG_PAR_IDX:
                    parIdx_r <= regWdata[2:0];
                `REG_PAR_DATA:
                begin
                    wrBuf_r[{parIdx_r, 3'h0} +: 8] <= regWdata;
                    parIdx_r <= parIdx_r + 3'h1;
                end
                `REG_PAR_REQ:
                begin
                    parAck_r <= 1'b1;
                    parIdx_r <= 3'h0;
                    if (!parDir_r)
                        rdBuf_r <= pageVal;
                    else if (parNum_r == `PAR_META_NWK)
                        metaNwk_r <= wrBuf_r;
                    else if (parNum_r == `PAR_META_WK)
                        metaWk_r <= wrBuf_r;
                    else if (parNum_r == `PAR_FIFO_CTL)
                    begin
                        wmWk_r <= wrBuf_r[15:0];
                        wmNwk_r <= wrBuf_r[47:32];
                    end
                end
                default:
                    parAck_r <= parAck_r;
            endcase
        end
        else if (regRd && regAddr == `REG_PAR_DATA)
        begin
            parIdx_r <= parIdx_r + 3'h1;
        end
    end

    always @*
    begin
        rdNxt = 8'h0;
        case (regAddr)
            `REG_PAR_NUM: rdNxt = {1'b0, parNum_r};
            `REG_PAR_DIR: rdNxt = {7'h0, parDir_r};
            `REG_PAR_ACK: rdNxt = {7'h0, parAck_r};
            `REG_PAR_IDX: rdNxt = {5'h0, parIdx_r};
            `REG_PAR_DATA: rdNxt = rdBuf_r[{parIdx_r, 3'h0} +: 8];
            default:
            begin
                if (regAddr >= `REG_WIN_TS0 && regAddr <= `REG_WIN_TS3)
                    rdNxt = irqTime_r[{regAddr[1:0], 3'h0} +: 8];
            end
        endcase
    end

    always @(posedge mclk)
    begin
        if (rst)
            regRdata_r <= 8'h0;
        else if (regRd)
            regRdata_r <= rdNxt;
        else
            regRdata_r <= 8'h0;
    end
endmodule // system_parameter_page
`default_nettype wire

// *** tb/host_model.sv ***
// Host model: drives the register port one strobe at a time.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    // Clock.
    input wire logic mclk,
    // Register port.
    output var logic [7:0] regAddr,
    output var logic [7:0] regWdata,
    output var logic regWr,
    output var logic regRd,
    input wire logic [7:0] regRdata_r
);
    initial
    begin
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        d = regRdata_r;
    endtask
endmodule // host_model
`default_nettype wire

// *** tb/system_parameter_page_properties.sv ***
// Checker on the ports of the system parameter page.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module spp_checker
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Watched ports.
    input wire logic regRd,
    input wire logic [7:0] regRdata_r,
    input wire logic [31:0] metaEvtNwk,
    input wire logic [31:0] metaEvtWk,
    input wire logic [15:0] wkFifoLevel,
    input wire logic [15:0] nwkFifoLevel,
    input wire logic sampleZeroLat,
    input wire logic wakeupEvent,
    input wire logic host_suspended_flag,
    input wire logic [31:0] metaPushNwk_r,
    input wire logic [31:0] metaPushWk_r,
    input wire logic hostIrq_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire anyCause = sampleZeroLat | wakeupEvent | (|metaEvtNwk) | (|metaEvtWk) | (|wkFifoLevel) | (|nwkFifoLevel);
    rdata_idle_a: assert property (!$past(regRd) |-> regRdata_r == 8'h00)
        else $error("read data outside the read slot");
    push_nwk_a: assert property ((metaPushNwk_r & ~$past(metaEvtNwk)) == 32'h0)
        else $error("non-wakeup push without event");
    push_wk_a: assert property ((metaPushWk_r & ~$past(metaEvtWk)) == 32'h0)
        else $error("wakeup push without event");
    zero_lat_irq_a: assert property (sampleZeroLat && !host_suspended_flag |=> hostIrq_r)
        else $error("zero latency sample gave no interrupt");
    wake_irq_a: assert property (wakeupEvent |=> hostIrq_r)
        else $error("wakeup event gave no interrupt");
    irq_cause_a: assert property (!$past(anyCause) |-> !hostIrq_r)
        else $error("interrupt without cause");
    irq_stand_a: assert property (wakeupEvent ##1 wakeupEvent |-> hostIrq_r [*2])
        else $error("interrupt dropped while cause held");
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> !hostIrq_r && metaPushNwk_r == 32'h0)
        else $error("outputs not cleared by reset");
endmodule // spp_checker
bind system_parameter_page spp_checker u_spp_checker (.mclk(mclk), .rst(rst), .regRd(regRd),
    .regRdata_r(regRdata_r), .metaEvtNwk(metaEvtNwk), .metaEvtWk(metaEvtWk), .wkFifoLevel(wkFifoLevel),
    .nwkFifoLevel(nwkFifoLevel), .sampleZeroLat(sampleZeroLat), .wakeupEvent(wakeupEvent),
    .host_suspended_flag(host_suspended_flag), .metaPushNwk_r(metaPushNwk_r), .metaPushWk_r(metaPushWk_r),
    .hostIrq_r(hostIrq_r));
`default_nettype wire

// *** tb/test_system_parameter_page.sv ***
// Self-checking bench for the system parameter page.
// Assumes the host model owns the register port; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module test_system_parameter_page;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr, regWdata, regRdata_r, b;
    logic regWr, regRd, hostIrq_r, sampleZeroLat = 1'b0, wakeupEvent = 1'b0, host_suspended_flag = 1'b1;
    logic [511:0] sensorStatus;
    logic [31:0] metaEvtNwk = 32'h0, metaEvtWk = 32'h0, metaPushNwk_r, metaPushWk_r;
    logic [15:0] wkFifoLevel = 16'h0, nwkFifoLevel = 16'h0;
    logic [63:0] got;
    int n_errors = 0;
    int total_checks = 0;
    typedef struct {logic [6:0] num; logic [63:0] exp;} row_t;
    row_t rows [6];
    always #20 mclk = ~mclk;
    host_model u_host_model (.mclk(mclk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata_r(regRdata_r));
    system_parameter_page u_system_parameter_page (.mclk(mclk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_r(regRdata_r), .sensorStatus(sensorStatus),
        .metaEvtNwk(metaEvtNwk), .metaEvtWk(metaEvtWk), .wkFifoLevel(wkFifoLevel), .nwkFifoLevel(nwkFifoLevel),
        .sampleZeroLat(sampleZeroLat), .wakeupEvent(wakeupEvent), .host_suspended_flag(host_suspended_flag),
        .metaPushNwk_r(metaPushNwk_r), .metaPushWk_r(metaPushWk_r), .hostIrq_r(hostIrq_r));
    task chk(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Read transfers land in got; the acknowledge is checked on every transfer.
    task xfer(input logic [6:0] num, input logic dir, input logic [63:0] w);
        u_host_model.wr(8'h00, {1'b0, num});
        u_host_model.wr(8'h01, {7'h0, dir});
        u_host_model.wr(8'h04, 8'h00);
        for (int i = 0; i < 8; i++)
            if (dir) u_host_model.wr(8'h05, w[8*i +: 8]);
        u_host_model.wr(8'h02, 8'h00);
        u_host_model.rd(8'h03, b);
        chk({56'h0, b}, 64'h1);
        for (int i = 0; i < 8; i++)
            if (!dir) begin u_host_model.rd(8'h05, b); got[8*i +: 8] = b; end
    endtask
    task print_verdict;
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #400000;
        n_errors++;
        print_verdict;
    end
    initial
    begin
        for (int t = 1; t <= 64; t++)
            sensorStatus[8*t-8 +: 8] = t[7:0];
        rows = '{'{7'h03, 64'h0807060504030201}, '{7'h04, 64'h1817161514131211},
            '{7'h05, 64'h2827262524232221}, '{7'h06, 64'h3837363534333231}, '{7'h07, 64'h0}, '{7'h1c, 64'h0}};
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            u_host_model.rd(8'h6c + i[7:0], b);
            chk({56'h0, b}, 64'h0);
        end
        xfer(7'h03, 1'b1, '1);
        xfer(7'h07, 1'b1, '1);
        foreach (rows[i])
        begin
            xfer(rows[i].num, 1'b0, 64'h0);
            chk(got, rows[i].exp);
        end
        xfer(7'h02, 1'b1, 64'hffff0000ffffffff);
        xfer(7'h02, 1'b0, 64'h0);
        chk(got, 64'h080000000800ffff);
        nwkFifoLevel <= 16'h0800;
        wkFifoLevel <= 16'h07ff;
        repeat (3) @(posedge mclk);
        #1 chk({63'h0, hostIrq_r}, 64'h0);
        wkFifoLevel <= 16'h0800;
        repeat (3) @(posedge mclk);
        #1 chk({63'h0, hostIrq_r}, 64'h1);
        wkFifoLevel <= 16'h0;
        nwkFifoLevel <= 16'h0;
        xfer(7'h01, 1'b1, 64'h2);
        xfer(7'h1d, 1'b1, 64'h3);
        xfer(7'h01, 1'b0, 64'h0);
        chk(got, 64'h2);
        @(posedge mclk);
        metaEvtNwk <= 32'h3;
        metaEvtWk <= 32'h3;
        @(posedge mclk);
        metaEvtNwk <= 32'h0;
        metaEvtWk <= 32'h0;
        #1 chk({metaPushNwk_r, metaPushWk_r}, 64'h0000000100000001);
        chk({63'h0, hostIrq_r}, 64'h1);
        xfer(7'h1e, 1'b1, 64'h0);
        xfer(7'h1e, 1'b0, 64'h0);
        for (int i = 0; i < 4; i++)
        begin
            u_host_model.rd(8'h6c + i[7:0], b);
            chk({56'h0, b}, {56'h0, got[8*i +: 8]});
        end
        host_suspended_flag <= 1'b0;
        sampleZeroLat <= 1'b1;
        @(posedge mclk);
        sampleZeroLat <= 1'b0;
        wakeupEvent <= 1'b1;
        #1 chk({63'h0, hostIrq_r}, 64'h1);
        repeat (2) @(posedge mclk);
        wakeupEvent <= 1'b0;
        repeat (3) @(posedge mclk);
        print_verdict;
    end
endmodule // test_system_parameter_page
`default_nettype wire
